// *** verilog/can_command_status_regs.v ***
// Function
// - command register at address 1, bits input0/1 select, wake, sleep, clear, release, abort, request
// - bits 0..3 read as one; upper bits read back as state
// - writing one to transmit request starts transmission; zero does nothing
// - writing zero later never cancels a pending request
// - abort cancels a pending request not yet on the bus
// - release command frees the receive buffer held by the host
// - writing one to clear overrun clears the overrun flag
// - sleep bit enters sleep only with no interrupt pending and idle bus
// - sleep ends on bit cleared or bus activity; wake pulse raised
// - after bus wake, reception waits for a bus-free condition
// - sleep bit reads actual sleep state
// - wake mode selects single-ended or differential wake source
// - input select bits route inputs to comparator or reference; 00 keeps routing
// - input select bits read back switch state
// - read-only status register at address 2 with eight status bits
// - bus free is eleven consecutive recessive bits
// - setting transmit request clears the tx complete flag
// - release clears rx full; a stored message sets it again
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "can_cmd_map.vh"
module can_command_status_regs (
   input wire clock,
   input wire rst_n,
   input wire reset_request,
   input wire [2:0] address,
   input wire [7:0] write_data,
   input wire write_strobe,
   input wire read_strobe,
   output reg [7:0] read_data,
   input wire tx_started,
   input wire tx_done_ok,
   input wire tx_finished,
   input wire msg_stored,
   input wire overrun_event,
   input wire bus_off_flag,
   input wire error_flag,
   input wire transmitting_flag,
   input wire receiving_flag,
   input wire interrupt_pending,
   input wire bit_tick,
   input wire bus_recessive,
   input wire wake_differential,
   input wire wake_single_ended,
   output reg tx_pending,
   output reg abort_tx_pulse,
   output reg release_rx_buffer,
   output reg clear_overrun,
   output reg sleeping,
   output reg wake_mode,
   output reg wake_event,
   output reg rx_enable,
   output reg input0_select,
   output reg input1_select
);
   reg tx_complete_flag;
   reg tx_buffer_released;
   reg rx_buffer_full;
   reg overrun_flag;
   reg sleep_bit;
   reg wait_bus_free;
   wire bus_free;
   wire wr_cmd;
   wire bus_active;
   wire wake_seen;
   wire tx_req_wr;
   wire abort_ok;
   wire host_wake;
   wire bus_wake;
   wire sleep_ok;
   wire switch_wr;
   wire [7:0] status_value;
   reg [7:0] next_read;

   assign wr_cmd = write_strobe && (address == `ADDR_COMMAND);
   assign bus_active = bit_tick && !bus_recessive;
   // wake source picked by wake mode
   assign wake_seen = wake_mode ? wake_single_ended : wake_differential;

   // transmit commands, both refused while reset request is active
   assign tx_req_wr = wr_cmd && write_data[`CMD_TX_REQUEST] && !reset_request;
   // abort only reaches a request not yet on the bus; a request in the same write wins
   assign abort_ok = wr_cmd && write_data[`CMD_ABORT_TX] && !write_data[`CMD_TX_REQUEST] && !reset_request
                     && tx_pending && !tx_started;

   // wake causes while asleep: host clears the bit, or the bus moves
   assign host_wake = sleeping && wr_cmd && !write_data[`CMD_SLEEP];
   assign bus_wake = sleeping && !host_wake && (wake_seen || bus_active);

   // sleep entry needs a quiet bus and nothing pending
   assign sleep_ok = sleep_bit && !interrupt_pending && !bus_active && !transmitting_flag && !receiving_flag;

   // 00 in the select field leaves the switches alone
   assign switch_wr = wr_cmd && (write_data[`CMD_INPUT0_SELECT] || write_data[`CMD_INPUT1_SELECT]);

   // status word, fixed bit order
   assign status_value = {bus_off_flag, error_flag, transmitting_flag, receiving_flag,
                          tx_complete_flag, tx_buffer_released, overrun_flag, rx_buffer_full};

   bus_free_detect u_free (
      .clock(clock),
      .rst_n(rst_n),
      .bit_tick(bit_tick),
      .bus_recessive(bus_recessive),
      .restart(sleeping),
      .bus_free(bus_free)
   );

   // abort pulse, one cycle after the write
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         abort_tx_pulse <= 1'b0;
      end else begin
         abort_tx_pulse <= wr_cmd && write_data[`CMD_ABORT_TX] && !reset_request;
      end
   end

   // release pulse, one cycle after the write
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         release_rx_buffer <= 1'b0;
      end else begin
         release_rx_buffer <= wr_cmd && write_data[`CMD_RELEASE_RX] && !reset_request;
      end
   end

   // clear overrun pulse, one cycle after the write
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clear_overrun <= 1'b0;
      end else begin
         clear_overrun <= wr_cmd && write_data[`CMD_CLEAR_OVERRUN];
      end
   end

   // pending request; a zero written later never drops it
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_pending <= 1'b0;
      end else if (reset_request) begin
         tx_pending <= 1'b0;
      end else if (tx_req_wr) begin
         tx_pending <= 1'b1;
      end else if (abort_ok) begin
         tx_pending <= 1'b0;
      end else if (tx_started) begin
         tx_pending <= 1'b0;
      end
   end

   // transmit buffer lock, freed by abort or end of send
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_buffer_released <= 1'b1;
      end else if (reset_request) begin
         tx_buffer_released <= 1'b1;
      end else if (tx_req_wr) begin
         tx_buffer_released <= 1'b0;
      end else if (abort_ok || tx_finished) begin
         tx_buffer_released <= 1'b1;
      end
   end

   // transmission complete; an aborted message leaves it low
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_complete_flag <= 1'b1;
      end else if (tx_req_wr) begin
         tx_complete_flag <= 1'b0;
      end else if (tx_done_ok && !abort_ok && !reset_request) begin
         tx_complete_flag <= 1'b1;
      end
   end

   // receive full flag; a stored message beats a release
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_buffer_full <= 1'b0;
      end else if (msg_stored) begin
         rx_buffer_full <= 1'b1;
      end else if (release_rx_buffer) begin
         rx_buffer_full <= 1'b0;
      end
   end

   // overrun flag; a new overrun beats the clear
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overrun_flag <= 1'b0;
      end else if (overrun_event) begin
         overrun_flag <= 1'b1;
      end else if (clear_overrun) begin
         overrun_flag <= 1'b0;
      end
   end

   // host sleep request; a bus wake drops it
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sleep_bit <= 1'b0;
      end else begin
         if (wr_cmd) begin
            sleep_bit <= write_data[`CMD_SLEEP];
         end
         if (bus_wake) begin
            sleep_bit <= 1'b0;
         end
      end
   end

   // wake source choice written by the host
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_mode <= 1'b0;
      end else if (wr_cmd) begin
         wake_mode <= write_data[`CMD_WAKE_MODE];
      end
   end

   // actual sleep state and the wake pulse
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sleeping <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         wake_event <= host_wake || bus_wake;
         if (!sleeping && sleep_ok) begin
            sleeping <= 1'b1;
         end else if (host_wake || bus_wake) begin
            sleeping <= 1'b0;
         end
      end
   end

   // after a bus wake, hold reception off until the bus is free
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_bus_free <= 1'b0;
      end else if (bus_wake) begin
         wait_bus_free <= 1'b1;
      end else if (wait_bus_free && bus_free) begin
         wait_bus_free <= 1'b0;
      end
   end

   // receive enable
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_enable <= 1'b1;
      end else begin
         rx_enable <= !sleeping && !(wait_bus_free && !bus_free);
      end
   end

   // input 0 switch
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input0_select <= 1'b1;
      end else if (switch_wr) begin
         input0_select <= write_data[`CMD_INPUT0_SELECT];
      end
   end

   // input 1 switch
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input1_select <= 1'b1;
      end else if (switch_wr) begin
         input1_select <= write_data[`CMD_INPUT1_SELECT];
      end
   end

   // read mux
   always @* begin
      next_read = 8'h00;
      case (address)
         `ADDR_COMMAND: begin
            next_read = {input0_select, input1_select, wake_mode, sleeping, 4'hf};
         end
         `ADDR_STATUS: begin
            next_read = status_value;
         end
         default: begin
            next_read = 8'h00;
         end
      endcase
   end

   // read data registered, valid only the cycle after the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         read_data <= 8'h00;
      end else if (read_strobe) begin
         read_data <= next_read;
      end else begin
         read_data <= 8'h00;
      end
   end
endmodule

// *** include/can_cmd_map.vh ***
`ifndef CAN_CMD_MAP_VH
`define CAN_CMD_MAP_VH
// register offsets
`define ADDR_COMMAND 3'h1
`define ADDR_STATUS 3'h2
// command bit positions
`define CMD_TX_REQUEST 0
`define CMD_ABORT_TX 1
`define CMD_RELEASE_RX 2
`define CMD_CLEAR_OVERRUN 3
`define CMD_SLEEP 4
`define CMD_WAKE_MODE 5
`define CMD_INPUT1_SELECT 6
`define CMD_INPUT0_SELECT 7
// status bit positions
`define STAT_RX_FULL 0
`define STAT_OVERRUN 1
`define STAT_TX_RELEASED 2
`define STAT_TX_COMPLETE 3
`define STAT_RECEIVING 4
`define STAT_TRANSMITTING 5
`define STAT_ERROR 6
`define STAT_BUS_OFF 7
// reset values
`define RESET_UPPER 4'h0
`define RESET_SWITCHES 2'h3
// bus-free recessive bit count
`define BUS_FREE_BITS 4'hb
`endif

// *** verilog/bus_free_detect.v ***
`timescale 1ns/1ns
`include "can_cmd_map.vh"
module bus_free_detect (
   input wire clock,
   input wire rst_n,
   input wire bit_tick,
   input wire bus_recessive,
   input wire restart,
   output reg bus_free
);
   reg [3:0] run;

   // count consecutive recessive bits, flag at eleven
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run <= 4'h0;
         bus_free <= 1'b0;
      end else if (restart) begin
         run <= 4'h0;
         bus_free <= 1'b0;
      end else if (bit_tick) begin
         if (!bus_recessive) begin
            run <= 4'h0;
            bus_free <= 1'b0;
         end else if (run != `BUS_FREE_BITS) begin
            run <= run + 4'h1;
            bus_free <= (run == `BUS_FREE_BITS - 4'h1);
         end
      end
   end
endmodule

// *** verification/can_engine_model.sv ***
`timescale 1ns/1ns
module can_engine_model (
   input wire clock,
   input wire rst_n,
   input wire go,
   input wire tx_pending,
   output reg tx_started,
   output reg tx_done_ok,
   output reg tx_finished,
   output reg bit_tick
);
   reg [1:0] count;
   // bit time every 4 clocks; a send starts only when go
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= 2'h0;
         bit_tick <= 1'b0;
         tx_started <= 1'b0;
         tx_done_ok <= 1'b0;
         tx_finished <= 1'b0;
      end else begin
         count <= count + 2'h1;
         bit_tick <= count == 2'h3;
         tx_started <= go && tx_pending && !tx_started;
         tx_done_ok <= tx_started;
         tx_finished <= tx_started;
      end
   end
endmodule

// *** verification/can_cmd_properties.sv ***
`timescale 1ns/1ns
module can_cmd_chk (
   input wire clock,
   input wire rst_n,
   input wire reset_request,
   input wire [2:0] address,
   input wire [7:0] write_data,
   input wire write_strobe,
   input wire read_strobe,
   input wire [7:0] read_data,
   input wire interrupt_pending,
   input wire tx_started,
   input wire tx_pending,
   input wire abort_tx_pulse,
   input wire release_rx_buffer,
   input wire clear_overrun,
   input wire sleeping,
   input wire wake_mode,
   input wire wake_event,
   input wire input0_select,
   input wire input1_select
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // command writes, and those not blocked by reset request
   wire wc = write_strobe && address == 3'h1;
   wire wt = wc && !reset_request;
   wire [1:0] sw = write_data[7:6];
   wire wr_rel = wt && write_data[2];
   sequence s_woke; sleeping ##1 !sleeping; endsequence
   property p_txr; wt && write_data[0] |=> tx_pending; endproperty
   a_txr: assert property (p_txr) else $error("request lost");
   property p_hold; tx_pending && wt && write_data[1:0] == 2'h0 && !tx_started |=> tx_pending; endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_abt; wt && write_data[1:0] == 2'h2 |=> abort_tx_pulse; endproperty
   a_abt: assert property (p_abt) else $error("no abort");
   property p_rel; wt && write_data[2] |=> release_rx_buffer; endproperty
   a_rel: assert property (p_rel) else $error("no release");
   property p_cos; wc && write_data[3] |=> clear_overrun; endproperty
   a_cos: assert property (p_cos) else $error("no clear");
   property p_once; release_rx_buffer |-> $past(wr_rel); endproperty
   a_once: assert property (p_once) else $error("stray release");
   property p_rd; read_strobe && address == 3'h1 |=>
      read_data == {$past(input0_select), $past(input1_select), $past(wake_mode), $past(sleeping), 4'hf}; endproperty
   a_rd: assert property (p_rd) else $error("bad command read");
   property p_sel; wc && sw == 2'h2 |=> input0_select && !input1_select; endproperty
   a_sel: assert property (p_sel) else $error("bad switch");
   property p_keep; wc && sw == 2'h0 |=> $stable({input0_select, input1_select}); endproperty
   a_keep: assert property (p_keep) else $error("switch moved");
   property p_slp; !sleeping && interrupt_pending |=> !sleeping; endproperty
   a_slp: assert property (p_slp) else $error("slept");
   property p_wake; s_woke |-> ##[0:1] wake_event; endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse");
endmodule
bind can_command_status_regs can_cmd_chk u_chk (.*);

// *** verification/can_command_status_regs_tb.sv ***
`timescale 1ns/1ns
module can_command_status_regs_tb;
   reg clock = 1'b0, rst_n = 1'b0, reset_request = 1'b0, go = 1'b0;
   reg write_strobe = 1'b0, read_strobe = 1'b0, msg_stored = 1'b0, overrun_event = 1'b0;
   reg interrupt_pending = 1'b0, wake_single_ended = 1'b0, bus_off_flag = 1'b1, error_flag = 1'b0;
   reg receiving_flag = 1'b1;
   reg [2:0] address = 3'h0;
   reg [7:0] write_data = 8'h00;
   wire bus_recessive = 1'b1, wake_differential = 1'b0, transmitting_flag = 1'b0;
   wire [7:0] read_data;
   wire tx_pending, abort_tx_pulse, release_rx_buffer, clear_overrun, sleeping, wake_mode, wake_event;
   wire rx_enable, input0_select, input1_select, tx_started, tx_done_ok, tx_finished, bit_tick;
   integer err_count = 0, checked = 0, i;
   can_command_status_regs dut (.*);
   can_engine_model eng (.*);
   always #4 clock = ~clock;
   task report_and_stop;
      if (err_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task cmp(input string n, input [7:0] e, input [7:0] s);
      checked = checked + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input [7:0] d);
      @(posedge clock);
      address <= 3'h1;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task rd(input [2:0] a, input [7:0] e);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      cmp("read_data", e, read_data);
   endtask
   // bounded wait for a sleep state
   task wait_sleep(input e);
      for (i = 0; i < 200 && sleeping !== e; i = i + 1)
         @(posedge clock);
      if (sleeping !== e) begin
         err_count = err_count + 1;
         report_and_stop;
      end
   endtask
   initial begin
      #200000;
      err_count = err_count + 1;
      report_and_stop;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(3'h1, 8'hcf);
      rd(3'h2, 8'h9c);
      rd(3'h5, 8'h00);
      @(posedge clock);
      reset_request <= 1'b1;
      wr(8'h81);
      @(negedge clock);
      cmp("tx_pending", 8'h00, {7'h0, tx_pending});
      rd(3'h1, 8'h8f);
      wr(8'h00);
      rd(3'h1, 8'h8f);
      wr(8'h40);
      rd(3'h1, 8'h4f);
      wr(8'hc0);
      rd(3'h1, 8'hcf);
      @(posedge clock);
      reset_request <= 1'b0;
      wr(8'hc1);
      rd(3'h2, 8'h90);
      wr(8'hc0);
      @(negedge clock);
      cmp("tx_pending", 8'h01, {7'h0, tx_pending});
      wr(8'hc2);
      @(negedge clock);
      cmp("tx_pending", 8'h00, {7'h0, tx_pending});
      rd(3'h2, 8'h94);
      wr(8'hc1);
      go <= 1'b1;
      for (i = 0; i < 20 && !tx_finished; i = i + 1)
         @(posedge clock);
      go <= 1'b0;
      if (i == 20) begin
         err_count = err_count + 1;
         report_and_stop;
      end
      rd(3'h2, 8'h9c);
      @(posedge clock);
      msg_stored <= 1'b1;
      @(posedge clock);
      msg_stored <= 1'b0;
      overrun_event <= 1'b1;
      @(posedge clock);
      overrun_event <= 1'b0;
      rd(3'h2, 8'h9f);
      wr(8'hc4);
      rd(3'h2, 8'h9e);
      wr(8'hcc);
      rd(3'h2, 8'h9c);
      @(posedge clock);
      interrupt_pending <= 1'b1;
      receiving_flag <= 1'b0;
      wr(8'hf0);
      repeat (4) @(posedge clock);
      rd(3'h1, 8'hef);
      @(posedge clock);
      interrupt_pending <= 1'b0;
      wait_sleep(1'b1);
      rd(3'h1, 8'hff);
      @(posedge clock);
      wake_single_ended <= 1'b1;
      wait_sleep(1'b0);
      @(negedge clock);
      cmp("rx_enable", 8'h00, {7'h0, rx_enable});
      @(posedge clock);
      wake_single_ended <= 1'b0;
      rd(3'h1, 8'hef);
      for (i = 0; i < 100 && !rx_enable; i = i + 1)
         @(posedge clock);
      if (i == 100) begin
         err_count = err_count + 1;
         report_and_stop;
      end
      @(negedge clock);
      cmp("rx_enable", 8'h01, {7'h0, rx_enable});
      wr(8'hf0);
      wait_sleep(1'b1);
      wr(8'hc0);
      wait_sleep(1'b0);
      rd(3'h1, 8'hcf);
      report_and_stop;
   end
endmodule
